//--- design/ffb_cfg.svh
// offsets, field positions, reset values and counts of the fiber fault block
`ifndef FFB_CFG_SVH
`define FFB_CFG_SVH
// apb register byte addresses
`define FFB_OFS_CTRL 8'h00
`define FFB_OFS_STAT 8'h04
`define FFB_OFS_ISTAT 8'h08
`define FFB_OFS_IEN 8'h0C
`define FFB_OFS_ICLR 8'h10
// control register fields and reset value
`define FFB_CTRL_DUPLEX 0
`define FFB_CTRL_SPEED 1
`define FFB_CTRL_RST 2'h3
// status register fields
`define FFB_ST_FIBER 0
`define FFB_ST_SIGNAL 1
`define FFB_ST_FAULT 2
`define FFB_ST_FAULT_EN 3
`define FFB_ST_MII_B2B 4
`define FFB_ST_RMII_B2B 5
`define FFB_ST_TX_DIS 6
// interrupt status, enable and clear fields
`define FFB_IRQ_FAULT 0
`define FFB_IRQ_MODE 1
`define FFB_IRQ_TX_DIS 2
`define FFB_IRQ_W 3
// configuration strap codes
`define FFB_CFG_MII_B2B 3'h6
`define FFB_CFG_RMII_B2B 3'h5
// fault pattern length and strap settle count
`define FFB_FAULT_ONES 84
`define FFB_STRAP_WAIT 2'h3
`endif

//--- design/ffb_fef_pat.sv
// repeating far-end fault pattern: ONES one bits then a single zero
`timescale 1ns/1ps
module ffb_fault_pat #(
   parameter int ONES = 84
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_run,
   input wire logic i_step,
   output logic o_bit
);
   localparam int CW = $clog2(ONES + 1);
   localparam logic [CW-1:0] LAST = CW'(ONES);
   logic [CW-1:0] cnt_r; // bit position inside the pattern
   logic [CW-1:0] cnt_nxt;

   // a pattern without ones would be a stuck zero
   if (ONES < 1) begin : g_bad_ones
      $error("ffb_fault_pat: at least one one bit");
   end

   // next position: restart when idle, wrap after the zero bit
   always_comb begin
      cnt_nxt = cnt_r;
      if (!i_run) begin
         cnt_nxt = '0;
      end else if (i_step) begin
         cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
      end
   end

   // register
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // the zero sits only on the last position
   assign o_bit = (cnt_r != LAST);

   AST_PAT_WRAP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_run && i_step && cnt_r == LAST |=> cnt_r == '0)
      else $error("pattern did not wrap after the zero bit");
   AST_PAT_STEP: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) i_run && i_step && cnt_r != LAST
      |=> cnt_r == $past(cnt_r) + 1'b1)
      else $error("pattern position skipped a step");
endmodule : ffb_fault_pat

//--- design/ffb_pkg.sv
// types shared by the fiber fault and back-to-back block
package ffb_pkg;
   // strap capture sequence after reset
   typedef enum logic {
      FFB_S_WAIT,
      FFB_S_RUN
   } ffb_strap_st_t;
   // all pins that cross into the clock domain
   typedef struct packed {
      logic link_clk; // fiber bit clock from the link side
      logic fd_mid; // fiber detect above the lower threshold
      logic fd_high; // fiber detect above the upper threshold
      logic energy; // copper receive energy seen
      logic txd2; // transmit data bit 2 pin
      logic fd_strap_n; // fault disable strap, low disables
      logic [2:0] cfg; // configuration strap
   } ffb_pins_t;
   // media state seen on the fiber detect input
   typedef struct packed {
      logic fiber;
      logic signal;
      logic fault;
   } ffb_mode_t;
endpackage : ffb_pkg

//--- design/ffb_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module ffb_sync #(
   parameter int W = 9
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_r; // first stage, read only by q_r
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r; // second stage, safe to use
   logic [W-1:0] q_nxt;

   // refuse a bundle that no flop could hold
   if (W < 1) begin : g_bad_width
      $error("ffb_sync: width must be at least one");
   end

   // next values: shift the bundle one stage
   always_comb begin
      meta_nxt = i_d;
      q_nxt = meta_r;
   end

   // registers
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         q_r <= q_nxt;
      end
   end

   assign o_q = q_r;
endmodule : ffb_sync

//--- design/ffb_top.sv
// fiber detect, far-end fault and back-to-back mode logic with apb access
`timescale 1ns/1ps
`include "ffb_cfg.svh"

// What this block does
// - copper below low level, fiber above it
// - mid level means no signal, fault
// - high level means fiber signal present
// - fault sends 84 ones then one zero
// - fault on unless disable strap low
// - back-to-back copper side blocks 10 Mbps
// - strap 110 selects mii back-to-back
// - strap 101 selects rmii back-to-back
// - rmii copper side rxd2 shows receive energy
// - rmii: inverted energy high disables fiber transmitter
// - fiber bypasses coding, negotiation, fixes 100
module ffb_top (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_link_clk,
   input wire logic i_fd_mid,
   input wire logic i_fd_high,
   input wire logic i_energy,
   input wire logic i_txd2,
   input wire logic i_fault_disable_strap_n,
   input wire logic [2:0] i_cfg_strap,
   input wire logic i_fx_tx_data,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_fiber_mode,
   output logic o_signal_present,
   output logic o_far_end_fault,
   output logic o_fx_tx_bit,
   output logic o_fx_tx_disable,
   output logic o_block_10m,
   output logic o_bypass_coding,
   output logic o_skip_autoneg,
   output logic o_speed_100,
   output logic o_duplex_full,
   output logic o_mii_b2b,
   output logic o_rmii_b2b,
   output logic o_rxd2,
   output logic o_irq
);
   localparam int PW = $bits(ffb_pkg::ffb_pins_t);

   ffb_pkg::ffb_pins_t pins; // raw pins in one bundle
   ffb_pkg::ffb_pins_t s; // synchronised pins
   logic [PW-1:0] s_raw;
   logic pat_bit; // current fault pattern bit
   logic link_step; // rising edge of the link clock

   // strap capture state
   ffb_pkg::ffb_strap_st_t st_r, st_nxt;
   logic [1:0] wait_r, wait_nxt; // settle count after reset
   logic fault_en_r, fault_en_nxt; // far-end fault signalling on
   logic [2:0] cfg_r, cfg_nxt; // captured configuration strap

   // media state
   ffb_pkg::ffb_mode_t mode_r, mode_nxt;
   logic link_prev_r, link_prev_nxt; // last link clock level
   logic tx_bit_r, tx_bit_nxt;
   logic tx_dis_r, tx_dis_nxt;
   logic b10_r, b10_nxt;
   logic mii_r, mii_nxt;
   logic rmii_r, rmii_nxt;
   logic rxd2_r, rxd2_nxt;

   // register file and bus
   logic [1:0] ctrl_r, ctrl_nxt;
   logic [`FFB_IRQ_W-1:0] ist_r, ist_nxt; // sticky event bits
   logic [`FFB_IRQ_W-1:0] ien_r, ien_nxt; // event enables
   logic [`FFB_IRQ_W-1:0] ev; // events this cycle
   logic [`FFB_IRQ_W-1:0] clr; // clear strobes this cycle
   logic irq_r, irq_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic rdy_r, rdy_nxt;
   logic err_r, err_nxt;
   logic spd_r, spd_nxt; // 100 Mbps select, registered for the pin
   logic setup; // apb setup phase
   logic wr_acc; // write completes this edge
   logic hit; // address is mapped

   assign pins = '{link_clk: i_link_clk, fd_mid: i_fd_mid,
      fd_high: i_fd_high, energy: i_energy, txd2: i_txd2,
      fd_strap_n: i_fault_disable_strap_n, cfg: i_cfg_strap};

   // every detect, energy and txd2 pin, strap and link clock passes two flops first
   ffb_sync #(.W(PW)) u_sync (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_d(pins),
      .o_q(s_raw)
   );
   assign s = s_raw;

   // the link clock only paces the pattern, so edge finding is enough
   assign link_step = s.link_clk & ~link_prev_r;

   ffb_fault_pat #(.ONES(`FFB_FAULT_ONES)) u_pat (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_run(mode_r.fault),
      .i_step(link_step),
      .o_bit(pat_bit)
   );

   // strap capture: wait until the synchroniser holds real pin levels
   always_comb begin
      st_nxt = st_r;
      wait_nxt = wait_r;
      fault_en_nxt = fault_en_r;
      cfg_nxt = cfg_r;
      unique case (st_r)
         ffb_pkg::FFB_S_WAIT: begin
            wait_nxt = wait_r + 2'h1;
            if (wait_r == `FFB_STRAP_WAIT) begin
               st_nxt = ffb_pkg::FFB_S_RUN;
               fault_en_nxt = s.fd_strap_n;
               cfg_nxt = s.cfg;
            end
         end
         ffb_pkg::FFB_S_RUN: begin
            wait_nxt = wait_r;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= ffb_pkg::FFB_S_WAIT;
         wait_r <= 2'h0;
         fault_en_r <= 1'b1; // signalling on until straps say otherwise
         cfg_r <= 3'h0;
      end else begin
         st_r <= st_nxt;
         wait_r <= wait_nxt;
         fault_en_r <= fault_en_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   // media state, fault pattern and back-to-back outputs
   always_comb begin
      mode_nxt.fiber = s.fd_mid;
      mode_nxt.signal = s.fd_mid & s.fd_high;
      // no signal in fiber mode is a far-end fault when enabled
      mode_nxt.fault = s.fd_mid & ~s.fd_high & fault_en_r;
      link_prev_nxt = s.link_clk;
      // fault pattern replaces the data stream toward the partner
      tx_bit_nxt = mode_r.fault ? pat_bit : i_fx_tx_data;
      mii_nxt = (cfg_r == `FFB_CFG_MII_B2B);
      rmii_nxt = (cfg_r == `FFB_CFG_RMII_B2B);
      // copper side of a converter refuses a 10 Mbps link
      b10_nxt = (mii_r | rmii_r) & ~mode_r.fiber;
      // spare receive bit 2 carries copper energy to the peer
      rxd2_nxt = rmii_r & ~mode_r.fiber & s.energy;
      // fiber side stops its transmitter on a high bit 2 input
      tx_dis_nxt = rmii_r & mode_r.fiber & s.txd2;
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_r <= '0;
         link_prev_r <= 1'b0;
         tx_bit_r <= 1'b0;
         tx_dis_r <= 1'b0;
         b10_r <= 1'b0;
         mii_r <= 1'b0;
         rmii_r <= 1'b0;
         rxd2_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         link_prev_r <= link_prev_nxt;
         tx_bit_r <= tx_bit_nxt;
         tx_dis_r <= tx_dis_nxt;
         b10_r <= b10_nxt;
         mii_r <= mii_nxt;
         rmii_r <= rmii_nxt;
         rxd2_r <= rxd2_nxt;
      end
   end

   // apb slave: read data staged in setup so pready needs no wait
   assign setup = i_psel & ~i_penable;
   assign wr_acc = i_psel & i_penable & i_pwrite & rdy_r;
   assign hit = (i_paddr == `FFB_OFS_CTRL) || (i_paddr == `FFB_OFS_STAT) ||
      (i_paddr == `FFB_OFS_ISTAT) || (i_paddr == `FFB_OFS_IEN) ||
      (i_paddr == `FFB_OFS_ICLR);
   assign ev = {tx_dis_nxt & ~tx_dis_r, mode_nxt.fiber ^ mode_r.fiber,
      mode_nxt.fault & ~mode_r.fault};
   assign clr = (wr_acc && i_paddr == `FFB_OFS_ICLR) ?
      i_pwdata[`FFB_IRQ_W-1:0] : '0;

   always_comb begin
      ctrl_nxt = ctrl_r;
      ien_nxt = ien_r;
      rdata_nxt = rdata_r;
      rdy_nxt = setup; // answer in the first access cycle
      err_nxt = setup & ~hit; // unmapped address is an error
      // a new event wins over a clear in the same cycle
      ist_nxt = (ist_r & ~clr) | ev;
      irq_nxt = |(ist_nxt & ien_nxt);
      if (wr_acc && i_paddr == `FFB_OFS_CTRL) begin
         ctrl_nxt = i_pwdata[1:0];
      end
      if (wr_acc && i_paddr == `FFB_OFS_IEN) begin
         ien_nxt = i_pwdata[`FFB_IRQ_W-1:0];
      end
      irq_nxt = |(ist_nxt & ien_nxt);
      // fiber and the 10 Mbps block force 100, else software picks
      spd_nxt = mode_nxt.fiber | b10_nxt | ctrl_nxt[`FFB_CTRL_SPEED];
      if (setup) begin
         rdata_nxt = 32'h00000000;
         unique case (i_paddr)
            `FFB_OFS_CTRL: rdata_nxt[1:0] = ctrl_r;
            `FFB_OFS_STAT: rdata_nxt[6:0] = {tx_dis_r, rmii_r, mii_r,
               fault_en_r, mode_r.fault, mode_r.signal, mode_r.fiber};
            `FFB_OFS_ISTAT: rdata_nxt[`FFB_IRQ_W-1:0] = ist_r;
            `FFB_OFS_IEN: rdata_nxt[`FFB_IRQ_W-1:0] = ien_r;
            default: rdata_nxt = 32'h00000000; // clear reg, unmapped
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r <= `FFB_CTRL_RST;
         ist_r <= '0;
         ien_r <= '0;
         irq_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rdy_r <= 1'b0;
         err_r <= 1'b0;
         spd_r <= 1'b1; // matches the control reset value
      end else begin
         ctrl_r <= ctrl_nxt;
         ist_r <= ist_nxt;
         ien_r <= ien_nxt;
         irq_r <= irq_nxt;
         rdata_r <= rdata_nxt;
         rdy_r <= rdy_nxt;
         err_r <= err_nxt;
         spd_r <= spd_nxt;
      end
   end

   // outputs, all straight from flops
   assign o_prdata = rdata_r;
   assign o_pready = rdy_r;
   assign o_pslverr = err_r;
   assign o_fiber_mode = mode_r.fiber;
   assign o_signal_present = mode_r.signal;
   assign o_far_end_fault = mode_r.fault;
   assign o_fx_tx_bit = tx_bit_r;
   assign o_fx_tx_disable = tx_dis_r;
   assign o_block_10m = b10_r;
   // fiber bypasses coding and negotiation and runs at 100 only
   assign o_bypass_coding = mode_r.fiber;
   assign o_skip_autoneg = mode_r.fiber;
   assign o_speed_100 = spd_r;
   assign o_duplex_full = ctrl_r[`FFB_CTRL_DUPLEX]; // duplex stays free
   assign o_mii_b2b = mii_r;
   assign o_rmii_b2b = rmii_r;
   assign o_rxd2 = rxd2_r;
   assign o_irq = irq_r;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   AST_FIBER_IN: assert property (i_fd_mid [*4] |-> o_fiber_mode)
      else $error("fiber level did not select fiber mode");
   AST_COPPER_IN: assert property (!i_fd_mid [*4] |-> !o_fiber_mode)
      else $error("low level did not select copper mode");
   AST_FAULT: assert property (i_fd_mid && !i_fd_high && fault_en_r
      [*4] |-> o_far_end_fault && !o_signal_present)
      else $error("missing fiber signal raised no fault");
   AST_SIGNAL: assert property (i_fd_mid && i_fd_high [*4]
      |-> o_signal_present && o_fiber_mode && !o_far_end_fault)
      else $error("high level not seen as signal present");
   AST_PAT_OUT: assert property (o_far_end_fault && $fell(pat_bit)
      |=> !o_fx_tx_bit)
      else $error("fault pattern zero not sent");
   AST_STRAP: assert property (st_r == ffb_pkg::FFB_S_WAIT &&
      wait_r == `FFB_STRAP_WAIT |=> fault_en_r == $past(s.fd_strap_n))
      else $error("fault disable strap not captured");
   AST_NO_FAULT_OFF: assert property (!fault_en_r
      |=> !o_far_end_fault)
      else $error("fault raised while disabled");
   AST_B10: assert property (o_block_10m |-> $past(mii_r || rmii_r) &&
      $past(!mode_r.fiber))
      else $error("10 Mbps blocked outside back-to-back copper");
   AST_MODES: assert property ((o_mii_b2b |-> $past(cfg_r) == 3'h6) and
      (o_rmii_b2b |-> $past(cfg_r) == 3'h5))
      else $error("back-to-back mode does not match strap");
   AST_RXD2: assert property (rmii_r && !mode_r.fiber && s.energy
      |=> o_rxd2)
      else $error("copper energy not shown on rxd2");
   AST_TX_DIS: assert property (rmii_r && mode_r.fiber && s.txd2
      |=> o_fx_tx_disable)
      else $error("fiber transmitter not disabled");
   AST_FX_FIXED: assert property (o_fiber_mode |-> o_speed_100 &&
      o_skip_autoneg && o_bypass_coding)
      else $error("fiber mode not fixed at 100 without coding");
   AST_SET_WINS: assert property (|(ev & clr) |=> |(ist_r & $past(ev)))
      else $error("event lost against a clear");

   CVR_FAULT: cover property ($rose(o_far_end_fault));
   CVR_MII: cover property (o_mii_b2b);
   CVR_TX_DIS: cover property ($rose(o_fx_tx_disable));
   CVR_IRQ: cover property ($rose(o_irq));
endmodule : ffb_top

//--- verification/ffb_bench.sv
// self-checking bench for the fiber fault and back-to-back block
`timescale 1ns/1ps
`include "ffb_cfg.svh"
module fiber_fault_back_to_back_tb_top;
   logic clk, rst_n, lclk, fdm, fdh, energy, txd2, strap_n, txdata, run;
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [2:0] cfg; // configuration strap
   logic [1:0] level; // detect level asked of the optical model
   logic [7:0] paddr, last_run, zeros, z0;
   logic [31:0] pwdata, prdata, q;
   logic fiber, sig, fault, txbit, txdis, b10, byp, skip, spd, dup;
   logic mii, rmii, rxd2, irq;
   int n_mismatch = 0; // mismatches counted
   int samples_checked = 0; // comparisons made
   ffb_top u_ffb_top (.i_clock(clk), .i_rst_n(rst_n), .i_link_clk(lclk),
      .i_fd_mid(fdm), .i_fd_high(fdh), .i_energy(energy), .i_txd2(txd2),
      .i_fault_disable_strap_n(strap_n), .i_cfg_strap(cfg),
      .i_fx_tx_data(txdata), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .o_fiber_mode(fiber), .o_signal_present(sig), .o_far_end_fault(fault),
      .o_fx_tx_bit(txbit), .o_fx_tx_disable(txdis), .o_block_10m(b10),
      .o_bypass_coding(byp), .o_skip_autoneg(skip), .o_speed_100(spd),
      .o_duplex_full(dup), .o_mii_b2b(mii), .o_rmii_b2b(rmii),
      .o_rxd2(rxd2), .o_irq(irq));
   ffb_fiber_model u_ffb_fiber_model (.i_run(run), .i_level(level),
      .i_tx_bit(txbit), .o_link_clk(lclk), .o_fd_mid(fdm), .o_fd_high(fdh),
      .o_last_run(last_run), .o_zeros(zeros));
   // 100 ns clock for the block; the fiber model runs its own link clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %0h seen %0h", nm, e, s);
      end
   endtask : chk
   task automatic c1(input string nm, input logic s, input logic e);
      chk(nm, {31'h0, s}, {31'h0, e});
   endtask : c1
   // one apb transfer; the slave answer time is not assumed
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16)
         chk("pready", 32'h0, 32'h1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd
   // let the synchronisers and registered outputs land
   task automatic settle;
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic go(input logic [1:0] lv);
      @(posedge clk);
      level <= lv;
      settle();
   endtask : go
   // straps must stand still across the release of reset
   task automatic do_reset(input logic sn, input logic [2:0] c);
      @(posedge clk);
      rst_n <= 1'b0;
      strap_n <= sn;
      cfg <= c;
      level <= 2'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      settle();
   endtask : do_reset
   task automatic t_regs;
      rd(`FFB_OFS_CTRL);
      chk("ctrl", q, 32'h3);
      rd(`FFB_OFS_STAT);
      chk("stat", q, 32'h8);
      wr(`FFB_OFS_IEN, 32'h7);
      rd(`FFB_OFS_IEN);
      chk("ien", q, 32'h7);
      wr(`FFB_OFS_IEN, 32'h0);
      rd(8'h14);
      chk("unmapped", {q[30:0], err}, 32'h1);
      $display("test regs done");
   endtask : t_regs
   task automatic t_modes;
      wr(`FFB_OFS_CTRL, 32'h0);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         level <= i[1:0];
         txdata <= (i == 2);
         repeat (2) @(posedge clk);
         @(negedge clk);
         c1("fiber_early", fiber, i == 2);
         settle();
         c1("fiber", fiber, i != 0);
         c1("signal", sig, i == 2);
         c1("fault", fault, i == 1);
         c1("bypass", byp & skip, i != 0);
         c1("speed", spd, i != 0);
         c1("duplex", dup, 1'b0);
         c1("txbit", txbit, i != 0);
      end
      wr(`FFB_OFS_CTRL, 32'h3);
      $display("test modes done");
   endtask : t_modes
   task automatic t_irq;
      go(2'h0);
      wr(`FFB_OFS_ICLR, 32'h7);
      wr(`FFB_OFS_IEN, 32'h1);
      go(2'h1);
      c1("irq_fault", irq, 1'b1);
      rd(`FFB_OFS_ISTAT);
      chk("istat", q, 32'h3);
      wr(`FFB_OFS_ICLR, 32'h1);
      settle();
      c1("irq_masked", irq, 1'b0);
      wr(`FFB_OFS_IEN, 32'h2);
      settle();
      c1("irq_mode", irq, 1'b1);
      wr(`FFB_OFS_ICLR, 32'h2);
      settle();
      c1("irq_clr", irq, 1'b0);
      wr(`FFB_OFS_IEN, 32'h0);
      $display("test irq done");
   endtask : t_irq
   task automatic t_pattern;
      int n;
      n = 0;
      go(2'h2);
      z0 = zeros;
      @(posedge clk);
      level <= 2'h1;
      run <= 1'b1;
      while (8'(zeros - z0) < 8'h2 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      chk("ones_run", {24'h0, last_run}, `FFB_FAULT_ONES);
      c1("zeros_seen", 8'(zeros - z0) == 8'h2, 1'b1);
      @(posedge clk);
      run <= 1'b0;
      $display("test pattern done");
   endtask : t_pattern
   task automatic t_strap;
      do_reset(1'b0, 3'h0);
      go(2'h1);
      c1("fault_off", fault, 1'b0);
      c1("fiber_on", fiber, 1'b1);
      rd(`FFB_OFS_STAT);
      chk("stat_nofault", q, 32'h1);
      go(2'h2);
      c1("forced", fiber & ~fault, 1'b1);
      $display("test strap done");
   endtask : t_strap
   task automatic t_b2b;
      logic [2:0] codes [3];
      codes = '{3'h6, 3'h5, 3'h0};
      for (int i = 0; i < 3; i++) begin
         do_reset(1'b1, codes[i]);
         c1("mii", mii, codes[i] == 3'h6);
         c1("rmii", rmii, codes[i] == 3'h5);
         c1("block10", b10, codes[i] != 3'h0);
         wr(`FFB_OFS_CTRL, 32'h0);
         settle();
         c1("speed_b2b", spd, codes[i] != 3'h0);
         rd(`FFB_OFS_STAT);
         chk("stat_b2b", q & 32'h30, {26'h0, codes[i] == 3'h5,
             codes[i] == 3'h6, 4'h0});
         @(posedge clk);
         energy <= 1'b1;
         settle();
         c1("rxd2_on", rxd2, codes[i] == 3'h5);
         @(posedge clk);
         energy <= 1'b0;
         settle();
         c1("rxd2_off", rxd2, 1'b0);
         go(2'h2);
         @(posedge clk);
         // peer copper rxd2 low, seen high through the inverter
         txd2 <= 1'b1;
         settle();
         c1("txdis_on", txdis, codes[i] == 3'h5);
         rd(`FFB_OFS_ISTAT);
         chk("istat_txdis", q & 32'h4,
             {29'h0, codes[i] == 3'h5, 2'h0});
         @(posedge clk);
         txd2 <= 1'b0;
         settle();
         c1("txdis_off", txdis, 1'b0);
      end
      $display("test b2b done");
   endtask : t_b2b
   // watchdog: the whole run needs well under 20000 clocks
   initial begin
      #3000000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      rst_n = 1'b0;
      energy = 1'b0;
      txd2 = 1'b0;
      strap_n = 1'b1;
      cfg = 3'h0;
      txdata = 1'b0;
      run = 1'b0;
      level = 2'h0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      do_reset(1'b1, 3'h0);
      t_regs();
      t_modes();
      t_irq();
      t_pattern();
      t_strap();
      t_b2b();
      finish_test();
   end
endmodule : fiber_fault_back_to_back_tb_top

//--- verification/ffb_fiber_model.sv
// optical module model: detect levels, bit clock and fault pattern watcher
`timescale 1ns/1ps
module ffb_fiber_model (
   input wire logic i_run,
   input wire logic [1:0] i_level,
   input wire logic i_tx_bit,
   output logic o_link_clk,
   output logic o_fd_mid,
   output logic o_fd_high,
   output logic [7:0] o_last_run,
   output logic [7:0] o_zeros
);
   logic [7:0] run_cnt = 8'h00; // ones seen since the last zero
   logic [7:0] last_r = 8'h00; // length of the run before the last zero
   logic [7:0] zeros_r = 8'h00; // zeros seen so far
   // level 0 is below, 1 between and 2 above the two thresholds
   assign o_fd_mid = (i_level != 2'h0);
   assign o_fd_high = (i_level == 2'h2);
   assign o_last_run = last_r;
   assign o_zeros = zeros_r;
   // bit clock runs only while a frame is wanted, odd phase to the bench
   initial begin
      o_link_clk = 1'b0;
      #137;
      forever begin
         #400;
         o_link_clk = i_run ? ~o_link_clk : 1'b0;
      end
   end
   // sample at the next rising edge, long after the bit has settled
   always @(posedge o_link_clk) begin
      if (i_tx_bit === 1'b1) begin
         run_cnt <= run_cnt + 8'h01;
      end else begin
         last_r <= run_cnt;
         run_cnt <= 8'h00;
         zeros_r <= zeros_r + 8'h01;
      end
   end
endmodule : ffb_fiber_model
